/* hdl/prs_gating.sv */
// Peripheral reset pulsing and sleep clock gating with APB registers
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - A software reset request pulses the chosen peripheral's reset, then releases it.
// - Cleared sleep enable stops that peripheral's clock while the processor sleeps.
// - Run-enabled peripheral stopped in sleep resumes by itself after sleep ends.
// - Sleep gating never resets a peripheral; its state is kept throughout.
// - With gating off, sleep enables stay stored but are ignored in sleep.
// - Set sleep enable keeps the peripheral clocked in sleep; configuration unchanged.
// - A peripheral running in sleep may raise a wake event ending sleep.
module prs_gating
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [prs_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_sleep,
    input wire logic [prs_pkg::NUM_PERIPH-1:0] periph_wake,
    output logic [prs_pkg::NUM_PERIPH-1:0] periph_clk_en,
    output logic [prs_pkg::NUM_PERIPH-1:0] periph_rst,
    output logic wake_req,
    output logic irq
);
    import prs_pkg::*;

    logic [NUM_PERIPH-1:0] run_en;
    logic [NUM_PERIPH-1:0] sleep_en;
    logic gate_en;
    logic [NUM_PERIPH-1:0] rst_sel;
    logic [4:0] rst_count;
    prs_rst_state_t rst_state;
    logic [INT_WIDTH-1:0] int_stat;
    logic [INT_WIDTH-1:0] int_mask;
    logic [NUM_PERIPH-1:0] next_clk_en;
    logic [NUM_PERIPH-1:0] wake_src;
    logic setup_phase;
    logic wr_fire;
    logic rd_fire;
    logic rst_done_evt;
    logic wake_evt;

    function automatic logic hit(input logic [ADDR_WIDTH-1:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    function automatic logic mapped(input logic [ADDR_WIDTH-1:0] a);
        mapped = hit(a, OFF_RUN_EN) || hit(a, OFF_SLEEP_EN) || hit(a, OFF_CTRL)
            || hit(a, OFF_SW_RESET) || hit(a, OFF_STATUS) || hit(a, OFF_INT_STAT)
            || hit(a, OFF_INT_MASK);
    endfunction

    // Answer in the cycle after setup, so every access takes exactly two cycles
    assign setup_phase = psel && !penable;
    assign wr_fire = psel && penable && pready && pwrite && mapped(paddr);
    assign rd_fire = psel && penable && pready && !pwrite;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup_phase;
            pslverr <= setup_phase && !mapped(paddr);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (setup_phase && !pwrite)
        begin
            case (1'b1)
                hit(paddr, OFF_RUN_EN): prdata <= run_en;
                hit(paddr, OFF_SLEEP_EN): prdata <= sleep_en;
                hit(paddr, OFF_CTRL): prdata <= {31'h0000_0000, gate_en};
                hit(paddr, OFF_SW_RESET): prdata <= rst_sel;
                hit(paddr, OFF_STATUS):
                    prdata <= {30'h0000_0000, rst_state != PRS_IDLE, cpu_sleep};
                hit(paddr, OFF_INT_STAT): prdata <= {30'h0000_0000, int_stat};
                hit(paddr, OFF_INT_MASK): prdata <= {30'h0000_0000, int_mask};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Sleep settings persist whatever the gating switch says
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            run_en <= RUN_EN_RESET;
            sleep_en <= SLEEP_EN_RESET;
            gate_en <= GATE_EN_RESET;
            int_mask <= '0;
        end
        else if (wr_fire)
        begin
            if (hit(paddr, OFF_RUN_EN))
                run_en <= pwdata;
            if (hit(paddr, OFF_SLEEP_EN))
                sleep_en <= pwdata;
            if (hit(paddr, OFF_CTRL))
                gate_en <= pwdata[CTRL_GATE_BIT];
            if (hit(paddr, OFF_INT_MASK))
                int_mask <= pwdata[INT_WIDTH-1:0];
        end
    end

    // Writes to the reset register while a pulse runs are dropped
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rst_state <= PRS_IDLE;
            rst_sel <= '0;
            rst_count <= 5'h00;
        end
        else
        begin
            case (rst_state)
                PRS_IDLE:
                begin
                    if (wr_fire && hit(paddr, OFF_SW_RESET) && (pwdata != 32'h0000_0000))
                    begin
                        rst_sel <= pwdata;
                        rst_count <= RST_PULSE_COUNT;
                        rst_state <= PRS_PULSE;
                    end
                end
                PRS_PULSE:
                begin
                    rst_count <= rst_count - 5'h01;
                    if (rst_count == 5'h01)
                        rst_state <= PRS_DONE;
                end
                PRS_DONE:
                begin
                    rst_sel <= '0;
                    rst_state <= PRS_IDLE;
                end
                default: rst_state <= PRS_IDLE;
            endcase
        end
    end

    assign rst_done_evt = (rst_state == PRS_DONE);

    // Reset output only from the pulse logic, never from gating
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            periph_rst <= '0;
        else if (rst_state == PRS_IDLE && wr_fire && hit(paddr, OFF_SW_RESET))
            periph_rst <= pwdata;
        else if (rst_state == PRS_PULSE && rst_count == 5'h01)
            periph_rst <= '0;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PERIPH; g++)
        begin : gen_clk
            // Gating off means the sleep setting counts as set
            assign next_clk_en[g] = run_en[g] &&
                (!cpu_sleep || !gate_en || sleep_en[g]);
            assign wake_src[g] = periph_wake[g] && next_clk_en[g];
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            periph_clk_en <= '0;
        else
            periph_clk_en <= next_clk_en;
    end

    assign wake_evt = cpu_sleep && (|wake_src);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            wake_req <= 1'b0;
        else
            wake_req <= wake_evt;
    end

    // Set beats the read clear so no event is lost
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            int_stat <= '0;
        else
        begin
            for (int i = 0; i < INT_WIDTH; i++)
            begin
                if (rd_fire && hit(paddr, OFF_INT_STAT))
                    int_stat[i] <= 1'b0;
            end
            if (rst_done_evt)
                int_stat[INT_RST_DONE_BIT] <= 1'b1;
            if (wake_evt)
                int_stat[INT_WAKE_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |(int_stat & int_mask);
    end

    clk_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
        ##1 periph_clk_en == $past(next_clk_en))
        else $error("clock enable does not follow settings");

    sleep_stop_a: assert property (@(posedge clk_sys) disable iff (reset)
        (cpu_sleep && gate_en && !sleep_en[0]) |=> !periph_clk_en[0])
        else $error("peripheral clocked in sleep without sleep enable");

    resume_run_a: assert property (@(posedge clk_sys) disable iff (reset)
        (!cpu_sleep && run_en[0]) |=> periph_clk_en[0])
        else $error("peripheral did not resume after sleep");

    gate_off_a: assert property (@(posedge clk_sys) disable iff (reset)
        (!gate_en && run_en[1]) |=> periph_clk_en[1])
        else $error("sleep setting applied while gating off");

    keep_run_a: assert property (@(posedge clk_sys) disable iff (reset)
        (cpu_sleep && sleep_en[2] && run_en[2]) |=> periph_clk_en[2])
        else $error("sleep enabled peripheral stopped");

    pulse_len_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(|periph_rst) |-> (|periph_rst) [*8] ##1 (|periph_rst) [*8] ##1 !(|periph_rst))
        else $error("reset pulse length wrong");

    no_gate_rst_a: assert property (@(posedge clk_sys) disable iff (reset)
        (rst_state == PRS_IDLE) |=> periph_rst == '0 || $past(wr_fire))
        else $error("reset asserted without request");

    wake_out_a: assert property (@(posedge clk_sys) disable iff (reset)
        (cpu_sleep && periph_wake[3] && next_clk_en[3]) |=> wake_req)
        else $error("wake event lost");

    apb_ready_a: assert property (@(posedge clk_sys) disable iff (reset)
        (psel && !penable) |=> pready)
        else $error("slave did not answer in one cycle");

    reset_pulse_c: cover property (@(posedge clk_sys) disable iff (reset)
        rst_state == PRS_DONE);
    sleep_gate_c: cover property (@(posedge clk_sys) disable iff (reset)
        cpu_sleep && gate_en && run_en[0] && !periph_clk_en[0]);
    wake_c: cover property (@(posedge clk_sys) disable iff (reset) wake_req);
    irq_c: cover property (@(posedge clk_sys) disable iff (reset) irq);
    gate_off_c: cover property (@(posedge clk_sys) disable iff (reset)
        !gate_en && cpu_sleep && run_en[1] && periph_clk_en[1]);

    // Whole-vector checks, so every peripheral bit is watched
    awake_all_a: assert property (@(posedge clk_sys) disable iff (reset)
        !cpu_sleep |=> periph_clk_en == $past(run_en))
        else $error("awake clock enables differ from run settings");

    sleep_all_a: assert property (@(posedge clk_sys) disable iff (reset)
        (cpu_sleep && gate_en) |=> periph_clk_en == $past(run_en & sleep_en))
        else $error("sleep clock enables differ from sleep settings");

    gate_off_all_a: assert property (@(posedge clk_sys) disable iff (reset)
        !gate_en |=> periph_clk_en == $past(run_en))
        else $error("sleep settings used while gating off");

    keep_set_a: assert property (@(posedge clk_sys) disable iff (reset)
        !(wr_fire && hit(paddr, OFF_SLEEP_EN)) |=> $stable(sleep_en))
        else $error("sleep settings changed without a write");

    keep_cfg_a: assert property (@(posedge clk_sys) disable iff (reset)
        (cpu_sleep && !wr_fire) |=> $stable(run_en) && $stable(gate_en))
        else $error("configuration changed during sleep");

    rst_load_a: assert property (@(posedge clk_sys) disable iff (reset)
        (rst_state == PRS_IDLE && wr_fire && hit(paddr, OFF_SW_RESET))
        |=> periph_rst == $past(pwdata))
        else $error("reset mask not applied");

    rst_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        (rst_state == PRS_PULSE && rst_count != 5'h01) |=> $stable(periph_rst))
        else $error("reset mask changed during pulse");

    rst_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
        (rst_state == PRS_DONE) |-> periph_rst == '0)
        else $error("reset still high after pulse");

    sleep_no_rst_a: assert property (@(posedge clk_sys) disable iff (reset)
        ($changed(cpu_sleep) && rst_state == PRS_IDLE && !wr_fire) |=> periph_rst == '0)
        else $error("sleep change raised a reset");

    done_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
        rst_done_evt |=> int_stat[INT_RST_DONE_BIT])
        else $error("reset done flag not set");

    wake_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
        wake_evt |=> int_stat[INT_WAKE_BIT])
        else $error("wake flag not set");

    irq_on_a: assert property (@(posedge clk_sys) disable iff (reset)
        (|(int_stat & int_mask)) |=> irq)
        else $error("interrupt missing");

    irq_off_a: assert property (@(posedge clk_sys) disable iff (reset)
        !(|(int_stat & int_mask)) |=> !irq)
        else $error("interrupt without unmasked flag");

    awake_no_wake_a: assert property (@(posedge clk_sys) disable iff (reset)
        !cpu_sleep |=> !wake_req)
        else $error("wake request while awake");

    err_resp_a: assert property (@(posedge clk_sys) disable iff (reset)
        (psel && !penable && !mapped(paddr)) |=> pslverr)
        else $error("unmapped access not flagged");

    ok_resp_a: assert property (@(posedge clk_sys) disable iff (reset)
        (psel && !penable && mapped(paddr)) |=> !pslverr)
        else $error("mapped access flagged");

    sleep_stat_a: assert property (@(posedge clk_sys) disable iff (reset)
        (psel && !penable && !pwrite && hit(paddr, OFF_STATUS))
        |=> prdata[STAT_SLEEP_BIT] == $past(cpu_sleep))
        else $error("status sleep bit wrong");

endmodule // prs_gating

`default_nettype wire

/* hdl/prs_pkg.sv */
// Package of constants for the peripheral reset and sleep gating block
package prs_pkg;
    localparam int unsigned NUM_PERIPH = 32;
    localparam int unsigned ADDR_WIDTH = 12;
    // Register byte offsets
    localparam logic [11:0] OFF_RUN_EN = 12'h000;
    localparam logic [11:0] OFF_SLEEP_EN = 12'h004;
    localparam logic [11:0] OFF_CTRL = 12'h008;
    localparam logic [11:0] OFF_SW_RESET = 12'h00c;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_INT_STAT = 12'h014;
    localparam logic [11:0] OFF_INT_MASK = 12'h018;
    // Field positions
    localparam int unsigned CTRL_GATE_BIT = 0;
    localparam int unsigned STAT_SLEEP_BIT = 0;
    localparam int unsigned STAT_RST_BUSY_BIT = 1;
    localparam int unsigned INT_RST_DONE_BIT = 0;
    localparam int unsigned INT_WAKE_BIT = 1;
    localparam int unsigned INT_WIDTH = 2;
    // Reset values
    localparam logic [31:0] RUN_EN_RESET = 32'h0000_0000;
    localparam logic [31:0] SLEEP_EN_RESET = 32'h0000_0000;
    localparam logic GATE_EN_RESET = 1'b0;
    // Peripheral reset pulse length
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned RST_PULSE_NS = 80;
    localparam int unsigned RST_PULSE_CYCLES =
        (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] RST_PULSE_COUNT = 5'(RST_PULSE_CYCLES);
    typedef enum logic [1:0] {
        PRS_IDLE = 2'b00,
        PRS_PULSE = 2'b01,
        PRS_DONE = 2'b11
    } prs_rst_state_t;
endpackage

/* sim/prs_periph_model.sv */
// Behavioural peripheral: a counter that runs only on its clock enable
`timescale 1ns/1ps
`default_nettype none
module prs_periph_model
#(
    parameter int IDX = 0
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [31:0] periph_clk_en,
    input wire logic [31:0] periph_rst,
    input wire logic fire,
    output logic [7:0] cnt,
    output logic [31:0] periph_wake
);
    // A gated peripheral has no clock, so it cannot signal a wake
    assign periph_wake = 32'(fire & periph_clk_en[IDX]) << IDX;
    always_ff @(posedge clk_sys)
    begin
        if (reset || periph_rst[IDX])
            cnt <= 8'h00;
        else if (periph_clk_en[IDX])
            cnt <= cnt + 8'h01;
    end
endmodule // prs_periph_model
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the reset pulse and sleep gating block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import prs_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic cpu_sleep = 1'b0;
    logic fire = 1'b0;
    logic [31:0] prdata, periph_clk_en, periph_rst, wk0, wk1, rd;
    logic pready, pslverr, wake_req, irq, err;
    logic [7:0] cnt0, cnt1, c;
    int n_errors = 0;
    int check_count = 0;
    int k;
    always #2.5 clk_sys = ~clk_sys;
    prs_gating DUT (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_sleep(cpu_sleep), .periph_wake(wk0 | wk1),
        .periph_clk_en(periph_clk_en), .periph_rst(periph_rst), .wake_req(wake_req), .irq(irq));
    prs_periph_model #(.IDX(0)) P0 (.clk_sys(clk_sys), .reset(reset),
        .periph_clk_en(periph_clk_en), .periph_rst(periph_rst), .fire(fire), .cnt(cnt0),
        .periph_wake(wk0));
    prs_periph_model #(.IDX(1)) P1 (.clk_sys(clk_sys), .reset(reset),
        .periph_clk_en(periph_clk_en), .periph_rst(periph_rst), .fire(1'b0), .cnt(cnt1),
        .periph_wake(wk1));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        check("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic t_reset_vals;
        apb(1'b0, OFF_RUN_EN, 32'h0);
        check("run reset", rd, RUN_EN_RESET);
        apb(1'b0, OFF_SLEEP_EN, 32'h0);
        check("sleep reset", rd, SLEEP_EN_RESET);
        apb(1'b0, OFF_CTRL, 32'h0);
        check("ctrl reset", rd, {31'h0, GATE_EN_RESET});
        apb(1'b0, OFF_INT_MASK, 32'h0);
        check("mask reset", rd, 32'h0000_0000);
        apb(1'b0, 12'h01c, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0000_0000);
    endtask
    task automatic t_gating;
        apb(1'b1, OFF_RUN_EN, 32'h0000_0003);
        apb(1'b1, OFF_SLEEP_EN, 32'h0000_0001);
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        repeat (3) @(posedge clk_sys);
        check("clk_en run", periph_clk_en, 32'h0000_0003);
        cpu_sleep <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check("clk_en sleep", periph_clk_en, 32'h0000_0001);
        c = cnt1;
        repeat (8) @(posedge clk_sys);
        check("gated state", {24'h0, cnt1}, {24'h0, c});
        check("no reset", periph_rst, 32'h0);
        cpu_sleep <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check("clk_en resume", periph_clk_en, 32'h0000_0003);
        check("runs again", {31'h0, cnt1 != c}, 32'h1);
    endtask
    task automatic t_gate_off;
        apb(1'b1, OFF_CTRL, 32'h0);
        cpu_sleep <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check("gate off", periph_clk_en, 32'h0000_0003);
        apb(1'b0, OFF_SLEEP_EN, 32'h0);
        check("kept setting", rd, 32'h0000_0001);
        cpu_sleep <= 1'b0;
    endtask
    task automatic t_wake;
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        apb(1'b1, OFF_INT_MASK, 32'h0000_0002);
        cpu_sleep <= 1'b1;
        repeat (3) @(posedge clk_sys);
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
        k = 0;
        repeat (5)
        begin
            @(posedge clk_sys);
            k += int'(wake_req === 1'b1);
        end
        check("wake pulses", 32'(k), 32'h1);
        check("wake irq", {31'h0, irq}, 32'h1);
        apb(1'b0, OFF_INT_STAT, 32'h0);
        check("wake flag", rd & 32'h2, 32'h2);
        cpu_sleep <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check("irq cleared", {31'h0, irq}, 32'h0);
    endtask
    task automatic t_rst_pulse;
        apb(1'b1, OFF_INT_MASK, 32'h0000_0001);
        apb(1'b1, OFF_SW_RESET, 32'h0000_0002);
        k = int'(periph_rst === 32'h0000_0002);
        repeat (30)
        begin
            @(posedge clk_sys);
            k += int'(periph_rst === 32'h0000_0002);
        end
        check("pulse length", 32'(k), 32'(RST_PULSE_CYCLES));
        check("periph reset", {24'h0, cnt1} < 32'd20, 32'h1);
        check("done irq", {31'h0, irq}, 32'h1);
        apb(1'b0, OFF_INT_STAT, 32'h0);
        check("done flag", rd & 32'h1, 32'h1);
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_reset_vals();
        t_gating();
        t_gate_off();
        t_wake();
        t_rst_pulse();
        report_and_stop();
    end
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        n_errors++;
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
